/* spp_core.sv */
// Sequential access port: data path, cycle control, pointer, start and end registers, flags
`timescale 1ns/10ps
module spp_core #(
  parameter int unsigned DATA_W     = spp_pkg::DATA_W,
  parameter int unsigned ADDR_W     = spp_pkg::ADDR_W,
  parameter int unsigned FIFO_DEPTH = spp_pkg::FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic [DATA_W-1:0]     seq_data_bus_in,
  output logic      [DATA_W-1:0]     seq_data_bus_out,
  output logic                       seq_data_bus_oe,
  input  wire logic                  seq_port_enable_n,
  input  wire logic                  seq_read_not_write,
  input  wire logic                  seq_output_enable_n,
  input  wire logic                  pointer_advance_n,
  input  wire logic                  pointer_direct_load_n,
  input  wire logic                  start_one_load_n,
  input  wire logic                  start_two_load_n,
  output logic                       buffer_one_end_flag_n,
  output logic                       buffer_two_end_flag_n,
  output logic      [ADDR_W-1:0]     seq_pointer,
  input  wire logic                  cmd_select_n,
  input  wire logic                  cmd_strobe,
  input  wire spp_pkg::spp_cmd_type  cmd,
  output logic                       cmd_ready,
  output spp_pkg::spp_wr_type        mem_wr,
  output logic                       mem_wr_valid,
  input  wire logic                  mem_wr_ready,
  output logic      [ADDR_W-1:0]     mem_rd_addr,
  input  wire logic [DATA_W-1:0]     mem_rd_data,
  output logic                       seq_stall
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  spp_pkg::spp_cycle_type cyc_reg;
  spp_pkg::spp_cycle_type cyc_next;
  logic [ADDR_W-1:0]  ptr_reg;
  logic [ADDR_W-1:0]  ptr_next;
  logic [ADDR_W-1:0]  hold_reg;
  logic [ADDR_W-1:0]  hold_next;
  logic               load_pend_reg;
  logic               load_pend_next;
  logic [ADDR_W-1:0]  start_reg [2];
  logic [ADDR_W-1:0]  start_next [2];
  logic [ADDR_W-1:0]  end_reg [2];
  logic [ADDR_W-1:0]  end_next [2];
  logic [1:0]         flag_n_reg;
  logic [1:0]         flag_n_next;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;
  logic               active_reg;
  logic               active_next;
  logic               fifo_in_ready;
  logic               fifo_in_valid;
  logic               inc;
  logic               cmd_ok;
  logic [1:0]         start_req;
  logic               step;
  spp_pkg::spp_wr_type wr_word;

  // ---------------------------------------------------------------
  // Write path through the FIFO
  // ---------------------------------------------------------------
  // Writes queue towards the array so a busy array stalls the port instead of dropping data
  assign seq_stall     = !fifo_in_ready;
  assign wr_word.addr  = ptr_reg;
  assign wr_word.data  = seq_data_bus_in;
  assign fifo_in_valid = !seq_port_enable_n && !seq_read_not_write;

  spp_fifo #(
    .WIDTH ($bits(spp_pkg::spp_wr_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (mem_wr)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  assign cmd_ok    = cmd_strobe && !cmd_select_n;
  assign cmd_ready = !cmd_select_n;
  assign start_req = {!start_two_load_n, !start_one_load_n};
  // Advance only on its own enable; random port chip enable plays no part
  assign inc       = !pointer_advance_n && !seq_stall;
  // A sampled direct load freezes the pointer, so only a free edge may step it
  assign step      = inc && pointer_direct_load_n && !load_pend_reg && start_req == 2'b00;

  always_comb begin
    cyc_next       = cyc_reg;
    ptr_next       = ptr_reg;
    hold_next      = hold_reg;
    load_pend_next = 1'b0;
    start_next     = start_reg;
    end_next       = end_reg;
    flag_n_next    = flag_n_reg;
    active_next    = !seq_port_enable_n;
    rdata_next     = rdata_reg;
    if (!pointer_direct_load_n) begin
      hold_next      = seq_data_bus_in[ADDR_W-1:0];
      load_pend_next = 1'b1;
    end
    // Pointer priority: delayed direct load, hold on a new direct load, start loads, then increment
    if (load_pend_reg) begin
      ptr_next = hold_reg;
    end else if (!pointer_direct_load_n) begin
      ptr_next = ptr_reg;
    end else if (start_req[0]) begin
      ptr_next = start_reg[0];
    end else if (start_req[1]) begin
      ptr_next = start_reg[1];
    end else if (inc) begin
      ptr_next = ptr_reg + 1'b1;
    end
    // Each flag tracks its own end register; set beats a same-cycle clear
    for (int i = 0; i < 2; i++) begin
      if (cmd_ok && !cmd.write_n && cmd.addr == spp_pkg::CTRL_ADDR && !cmd.data[i]) begin
        flag_n_next[i] = 1'b1;
      end
      if (step && (ptr_reg + 1'b1) == end_reg[i]) begin
        flag_n_next[i] = 1'b0;
      end
    end
    if (cmd_ok && !cmd.write_n) begin
      unique case (cmd.addr)
        spp_pkg::START1_ADDR: start_next[0] = cmd.data[ADDR_W-1:0];
        spp_pkg::END1_ADDR:   end_next[0]   = cmd.data[ADDR_W-1:0];
        spp_pkg::START2_ADDR: start_next[1] = cmd.data[ADDR_W-1:0];
        spp_pkg::END2_ADDR:   end_next[1]   = cmd.data[ADDR_W-1:0];
        default:              ;
      endcase
    end
    // Cycle tracking; a write ends when read_not_write or enable samples high
    if (seq_port_enable_n) begin
      cyc_next = spp_pkg::SPP_IDLE;
    end else if (!seq_read_not_write) begin
      cyc_next = spp_pkg::SPP_WRITE;
    end else if (!seq_output_enable_n) begin
      cyc_next = spp_pkg::SPP_READ;
    end else begin
      cyc_next = spp_pkg::SPP_IDLE;
    end
    if (!seq_port_enable_n && seq_read_not_write && !seq_output_enable_n) begin
      rdata_next = mem_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_reg       <= spp_pkg::SPP_IDLE;
      ptr_reg       <= spp_pkg::PTR_RESET;
      hold_reg      <= spp_pkg::REG_RESET;
      load_pend_reg <= 1'b0;
      start_reg     <= '{default: spp_pkg::REG_RESET};
      end_reg       <= '{default: spp_pkg::REG_RESET};
      flag_n_reg    <= 2'h3;
      rdata_reg     <= spp_pkg::DATA_RESET;
      active_reg    <= 1'b0;
    end else begin
      cyc_reg       <= cyc_next;
      ptr_reg       <= ptr_next;
      hold_reg      <= hold_next;
      load_pend_reg <= load_pend_next;
      start_reg     <= start_next;
      end_reg       <= end_next;
      flag_n_reg    <= flag_n_next;
      rdata_reg     <= rdata_next;
      active_reg    <= active_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mem_rd_addr           = ptr_reg;
  assign seq_pointer           = ptr_reg;
  assign seq_data_bus_out      = rdata_reg;
  // Output enable pin floats the bus without waiting for a clock; port enable acts through active_reg one clock later
  assign seq_data_bus_oe       = active_reg && !seq_output_enable_n && cyc_reg != spp_pkg::SPP_WRITE;
  assign buffer_one_end_flag_n = flag_n_reg[spp_pkg::FLAG1_BIT];
  assign buffer_two_end_flag_n = flag_n_reg[spp_pkg::FLAG2_BIT];
endmodule

/* spp_pkg.sv */
// Package: shared constants and carrier types for the sequential port pointer logic
package spp_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam logic [11:0] PTR_RESET   = 12'h000;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [11:0] REG_RESET   = 12'h000;
  localparam logic [2:0]  CTRL_ADDR   = 3'h5;
  localparam int unsigned FLAG1_BIT   = 0;
  localparam int unsigned FLAG2_BIT   = 1;
  localparam logic [2:0]  START1_ADDR = 3'h0;
  localparam logic [2:0]  END1_ADDR   = 3'h1;
  localparam logic [2:0]  START2_ADDR = 3'h2;
  localparam logic [2:0]  END2_ADDR   = 3'h3;

  typedef struct packed {
    logic        write_n;
    logic [2:0]  addr;
    logic [15:0] data;
  } spp_cmd_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
  } spp_wr_type;

  typedef enum logic [2:0] {
    SPP_IDLE  = 3'b001,
    SPP_READ  = 3'b010,
    SPP_WRITE = 3'b100
  } spp_cycle_type;
endpackage

/* spp_fifo.sv */
// FIFO: parameterised width and depth, valid and ready on both sides
`timescale 1ns/10ps
module spp_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_reg;
  logic [PW:0]      wr_next;
  logic [PW:0]      rd_reg;
  logic [PW:0]      rd_next;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (wr_reg - rd_reg) != (PW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_data  = mem[rd_reg[PW-1:0]];

  always_comb begin
    wr_next = do_wr ? wr_reg + 1'b1 : wr_reg;
    rd_next = do_rd ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end
endmodule

/* spp_props.sv */
// Checker: concurrent properties on the sequential port pointer logic
`timescale 1ns/10ps
module spp_props (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic [15:0]          seq_data_bus_in,
  input wire logic                 seq_data_bus_oe,
  input wire logic                 seq_port_enable_n,
  input wire logic                 seq_output_enable_n,
  input wire logic                 pointer_advance_n,
  input wire logic                 pointer_direct_load_n,
  input wire logic                 start_one_load_n,
  input wire logic                 start_two_load_n,
  input wire logic                 buffer_one_end_flag_n,
  input wire logic [11:0]          seq_pointer,
  input wire logic                 cmd_select_n,
  input wire logic                 cmd_strobe,
  input wire spp_pkg::spp_cmd_type cmd,
  input wire logic                 seq_stall
);
  // Shadow copies of the start and end registers
  logic [11:0] sh_reg [4];
  logic        ld_reg;
  wire         wr_cmd  = cmd_strobe && !cmd_select_n && !cmd.write_n;
  wire         clr_one = wr_cmd && cmd.addr == 3'h5 && !cmd.data[0];
  // A pending direct load or a full queue blocks the step
  wire         inc_ok  = !pointer_advance_n && pointer_direct_load_n && ld_reg && start_one_load_n &&
                         start_two_load_n && !seq_stall;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sh_reg <= '{default: 12'h000};
      ld_reg <= 1'b1;
    end else begin
      ld_reg <= pointer_direct_load_n;
      if (wr_cmd && !cmd.addr[2]) sh_reg[cmd.addr[1:0]] <= cmd.data[11:0];
    end
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_ptr_step_one: assert property (inc_ok |=> seq_pointer == $past(seq_pointer) + 12'h001)
    else $error("pointer step wrong");
  a_load_delay: assert property (!pointer_direct_load_n |=> $stable(seq_pointer) ##1
    seq_pointer == $past(seq_data_bus_in[11:0], 2)) else $error("direct load wrong");
  a_start_one_copy: assert property (!start_one_load_n && ld_reg && pointer_direct_load_n
    |=> seq_pointer == $past(sh_reg[0])) else $error("start one load wrong");
  a_start_two_copy: assert property (!start_two_load_n && start_one_load_n && ld_reg && pointer_direct_load_n
    |=> seq_pointer == $past(sh_reg[2])) else $error("start two load wrong");
  a_flag_set: assert property (inc_ok && seq_pointer + 12'h001 == sh_reg[1] |=> !buffer_one_end_flag_n)
    else $error("end flag not set");
  a_flag_sticky: assert property (!buffer_one_end_flag_n && !clr_one |=> !buffer_one_end_flag_n)
    else $error("end flag dropped");
  a_flag_clear: assert property (clr_one && !inc_ok |=> buffer_one_end_flag_n)
    else $error("end flag not cleared");
  a_bus_float: assert property (seq_output_enable_n || $past(seq_port_enable_n) |-> !seq_data_bus_oe)
    else $error("bus driven while off");
  c_flag_set: cover property (inc_ok && seq_pointer + 12'h001 == sh_reg[1]);
  c_direct_load: cover property (!pointer_direct_load_n);
  c_stall: cover property ($rose(seq_stall));
endmodule
bind spp_core spp_props spp_props_inst (.ref_clk, .resetn, .seq_data_bus_in, .seq_data_bus_oe, .seq_port_enable_n,
  .seq_output_enable_n, .pointer_advance_n, .pointer_direct_load_n, .start_one_load_n, .start_two_load_n,
  .buffer_one_end_flag_n, .seq_pointer, .cmd_select_n, .cmd_strobe, .cmd, .seq_stall);

/* spp_mem_model.sv */
// Partner model: buffer array behind the write queue, with a stall input
`timescale 1ns/10ps
module spp_mem_model (
  input  wire logic                ref_clk,
  input  wire logic                stall,
  input  wire spp_pkg::spp_wr_type mem_wr,
  input  wire logic                mem_wr_valid,
  output logic                     mem_wr_ready,
  input  wire logic [11:0]         mem_rd_addr,
  output logic      [15:0]         mem_rd_data
);
  logic [15:0] mem [4096];
  assign mem_wr_ready = !stall;
  assign mem_rd_data  = mem[mem_rd_addr];
  // Contents change only through accepted writes
  always_ff @(posedge ref_clk) begin
    if (mem_wr_valid && mem_wr_ready) mem[mem_wr.addr] <= mem_wr.data;
  end
endmodule

/* sequential_port_pointer_logic_tb.sv */
// Testbench: sequential port pointer logic driven cycle by cycle
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("unexpected %s exp %h seen %h", n, e, a); end end
module sequential_port_pointer_logic_tb;
  logic ref_clk = 1'b0, resetn = 1'b0, oe_n = 1'b0, stall = 1'b0, sel_n = 1'b1, stb = 1'b0, crdy;
  logic en_n = 1'b1, rnw = 1'b1, adv_n = 1'b1, ld_n = 1'b1, s1_n = 1'b1, s2_n = 1'b1, oe, f1_n, f2_n, wv, wrdy, stl;
  logic [15:0] din = 16'h0000, dout, rdat;
  logic [11:0] ptr, radr;
  spp_pkg::spp_cmd_type cmd = '0;
  spp_pkg::spp_wr_type wr;
  int bad_count = 0, n_checks = 0;
  wire [15:0] pin = oe ? dout : din;
  initial forever #12.5 ref_clk = ~ref_clk;
  spp_core spp_core_inst (.ref_clk, .resetn, .seq_data_bus_in(pin), .seq_data_bus_out(dout), .seq_data_bus_oe(oe),
    .seq_port_enable_n(en_n), .seq_read_not_write(rnw), .seq_output_enable_n(oe_n), .pointer_advance_n(adv_n),
    .pointer_direct_load_n(ld_n), .start_one_load_n(s1_n), .start_two_load_n(s2_n), .buffer_one_end_flag_n(f1_n),
    .buffer_two_end_flag_n(f2_n), .seq_pointer(ptr), .cmd_select_n(sel_n), .cmd_strobe(stb), .cmd, .cmd_ready(crdy),
    .mem_wr(wr), .mem_wr_valid(wv), .mem_wr_ready(wrdy), .mem_rd_addr(radr), .mem_rd_data(rdat), .seq_stall(stl));
  spp_mem_model spp_mem_model_inst (.ref_clk, .stall, .mem_wr(wr), .mem_wr_valid(wv), .mem_wr_ready(wrdy),
    .mem_rd_addr(radr), .mem_rd_data(rdat));
  // Control order: enable, read_not_write, advance, direct load, start one, start two
  task automatic st(input logic [5:0] c, input logic [15:0] d);
    @(negedge ref_clk);
    {en_n, rnw, adv_n, ld_n, s1_n, s2_n} = c;
    din = d;
  endtask
  task automatic go;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic cw(input logic [2:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {sel_n, stb} = 2'h1;
    cmd = '{1'b0, a, d};
    #1;
    `CHK("cmd ready", 1'b1, crdy)
    @(negedge ref_clk);
    {sel_n, stb} = 2'h2;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("ptr", 12'h000, ptr)
    `CHK("flags", 2'h3, {f1_n, f2_n})
    resetn = 1'b1;
    st(6'h3b, 16'hf123);
    st(6'h3f, 16'h0000);
    `CHK("ptr held", 12'h000, ptr)
    go();
    `CHK("ptr load", 12'h123, ptr)
    $display("done direct load");
    cw(3'h0, 16'h0100);
    cw(3'h1, 16'h0103);
    cw(3'h2, 16'h0200);
    cw(3'h3, 16'h0202);
    st(6'h35, 16'h0000);
    go();
    `CHK("ptr start", 12'h100, ptr)
    for (int i = 0; i < 3; i++) st(6'h07, 16'ha000 + 16'(i));
    repeat (6) st(6'h3f, 16'h0000);
    `CHK("ptr end", 12'h103, ptr)
    `CHK("flags", 2'h1, {f1_n, f2_n})
    `CHK("queue", 1'b0, wv)
    for (int i = 0; i < 3; i++) `CHK("mem", 16'ha000 + 16'(i), spp_mem_model_inst.mem[12'h100 + 12'(i)])
    st(6'h3d, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      st(6'h17, 16'h0000);
      go();
      `CHK("read", 16'ha000 + 16'(i), dout)
      `CHK("drive", 1'b1, oe)
    end
    st(6'h3f, 16'h0000);
    oe_n = 1'b1;
    #1;
    `CHK("float", 1'b0, oe)
    go();
    @(negedge ref_clk);
    oe_n = 1'b0;
    #1;
    `CHK("off", 1'b0, oe)
    cw(3'h5, 16'h0002);
    `CHK("flags", 2'h3, {f1_n, f2_n})
    $display("done buffer one");
    // Full queue must refuse the write and freeze the pointer
    stall = 1'b1;
    st(6'h3e, 16'h0000);
    for (int i = 0; i < 40 && stl !== 1'b1; i++) st(6'h07, 16'h5000 + 16'(i));
    go();
    `CHK("ptr full", 12'h220, ptr)
    `CHK("stall", 1'b1, stl)
    `CHK("flags", 2'h2, {f1_n, f2_n})
    stall = 1'b0;
    st(6'h3f, 16'h0000);
    for (int i = 0; i < 100 && wv !== 1'b0; i++) go();
    `CHK("drained", 1'b0, wv)
    `CHK("last", 16'h501f, spp_mem_model_inst.mem[12'h21f])
    $display("done stall");
    @(negedge ref_clk);
    resetn = 1'b0;
    #1;
    `CHK("ptr", 12'h000, ptr)
    `CHK("flags", 2'h3, {f1_n, f2_n})
    go();
    st(6'h27, 16'h0000);
    resetn = 1'b1;
    go();
    go();
    `CHK("ptr step", 12'h002, ptr)
    `CHK("no write", 1'b0, wv)
    $display("done reset");
    end_of_test();
  end
endmodule
